// *** logic/tcp_capture_timer.sv ***
// Capture timer channel: event counter and pulse period/width measurement
//
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module tcp_capture_timer #(
  parameter int CNT_W = 16
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire tcp_pkg::tcp_axi_req_t axi_req,
  output var  tcp_pkg::tcp_axi_rsp_t axi_rsp,
  input  wire logic                  capture_input_pin,
  input  wire logic                  subclock_tick,
  output logic                       irq_request
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin and sub-clock synchronisers, edge detection

  logic [2:0] pin_sync_r;
  logic [2:0] sub_sync_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_sync_r <= 3'h0;
      sub_sync_r <= 3'h0;
    end else begin
      pin_sync_r <= {pin_sync_r[1:0], capture_input_pin};
      sub_sync_r <= {sub_sync_r[1:0], subclock_tick};
    end
  end

  wire pin_rise = pin_sync_r[1] & ~pin_sync_r[2];
  wire pin_fall = ~pin_sync_r[1] & pin_sync_r[2];
  wire sub_tick = sub_sync_r[1] & ~sub_sync_r[2];

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  tcp_pkg::tcp_mode_t mode_r;
  logic               start_r;
  logic [CNT_W-1:0]   counter_r;
  logic [CNT_W-1:0]   reload_r;
  logic               irq_r;
  logic               ovf_r;
  logic               primed_r;
  logic [4:0]         main_div_r;
  logic [4:0]         sub_div_r;

  wire meas_mode = mode_r.mode_sel;

  // Effective edge selection
  wire ev_edge = (mode_r.edge_sel == tcp_pkg::EDGE_RISE) ? pin_rise :
                 (mode_r.edge_sel == tcp_pkg::EDGE_FALL) ? pin_fall :
                 (mode_r.edge_sel == tcp_pkg::EDGE_BOTH) ? (pin_rise | pin_fall) :
                 1'b0;
  wire ms_edge = mode_r.meas_type ? (pin_rise | pin_fall) : pin_rise;
  wire eff_edge = meas_mode ? ms_edge : ev_edge;

  // Count source prescaler
  wire main8_tick  = (main_div_r[2:0] == 3'(tcp_pkg::DIV_MAIN8 - 1));
  wire main32_tick = (main_div_r == 5'(tcp_pkg::DIV_MAIN32 - 1));
  wire sub32_tick  = sub_tick & (sub_div_r == 5'(tcp_pkg::DIV_SUB32 - 1));
  wire src_tick = (mode_r.clk_sel == tcp_pkg::SRC_MAIN_DIV1)  ? 1'b1 :
                  (mode_r.clk_sel == tcp_pkg::SRC_MAIN_DIV8)  ? main8_tick :
                  (mode_r.clk_sel == tcp_pkg::SRC_MAIN_DIV32) ? main32_tick :
                  sub32_tick;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  logic        aw_hold_r;
  logic        w_hold_r;
  logic [3:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  wire aw_take = axi_req.awvalid & ~aw_hold_r & ~bvalid_r;
  wire w_take  = axi_req.wvalid & ~w_hold_r & ~bvalid_r;
  wire wr_go   = aw_hold_r & w_hold_r & ~bvalid_r;
  wire ar_take = axi_req.arvalid & ~rvalid_r;

  // Next handshake state, so the ready outputs can be registered
  wire aw_hold_nxt = ~wr_go & (aw_hold_r | aw_take);
  wire w_hold_nxt  = ~wr_go & (w_hold_r | w_take);
  wire bvalid_nxt  = wr_go | (bvalid_r & ~axi_req.bready);
  wire rvalid_nxt  = ar_take | (rvalid_r & ~axi_req.rready);

  logic        awready_r;
  logic        wready_r;
  logic        arready_r;

  wire wr_count  = wr_go & (aw_addr_r == tcp_pkg::OFF_COUNT);
  wire wr_mode   = wr_go & (aw_addr_r == tcp_pkg::OFF_MODE) & w_strb_r[0];
  wire wr_start  = wr_go & (aw_addr_r == tcp_pkg::OFF_START) & w_strb_r[0];
  wire wr_status = wr_go & (aw_addr_r == tcp_pkg::OFF_STATUS) & w_strb_r[0];
  wire wr_ok     = wr_go & (aw_addr_r <= tcp_pkg::OFF_STATUS) & (aw_addr_r[1:0] == 2'h0);

  wire [CNT_W-1:0] wr_value = {w_strb_r[1] ? w_data_r[15:8] : reload_r[15:8],
                               w_strb_r[0] ? w_data_r[7:0]  : reload_r[7:0]};

  wire [3:0] ar_addr = axi_req.araddr;
  wire [CNT_W-1:0] count_view = meas_mode ? reload_r : counter_r;
  wire [31:0] rd_value =
    (ar_addr == tcp_pkg::OFF_COUNT)  ? {16'h0000, count_view} :
    (ar_addr == tcp_pkg::OFF_MODE)   ? {24'h000000, mode_r} :
    (ar_addr == tcp_pkg::OFF_START)  ? {31'h00000000, start_r} :
    (ar_addr == tcp_pkg::OFF_STATUS) ? {29'h00000000, primed_r, ovf_r, irq_r} :
    32'h00000000;
  wire rd_ok = (ar_addr <= tcp_pkg::OFF_STATUS) & (ar_addr[1:0] == 2'h0);

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      aw_addr_r <= 4'h0;
      w_data_r  <= 32'h00000000;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= tcp_pkg::RESP_OKAY;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h00000000;
      rresp_r   <= tcp_pkg::RESP_OKAY;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      arready_r <= 1'b1;
    end else begin
      awready_r <= ~aw_hold_nxt & ~bvalid_nxt;
      wready_r  <= ~w_hold_nxt & ~bvalid_nxt;
      arready_r <= ~rvalid_nxt;
      if (aw_take) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= axi_req.awaddr;
      end
      if (w_take) begin
        w_hold_r <= 1'b1;
        w_data_r <= axi_req.wdata;
        w_strb_r <= axi_req.wstrb;
      end
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_ok ? tcp_pkg::RESP_OKAY : tcp_pkg::RESP_SLVERR;
      end else if (bvalid_r & axi_req.bready) begin
        bvalid_r <= 1'b0;
      end
      if (ar_take) begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_value;
        rresp_r  <= rd_ok ? tcp_pkg::RESP_OKAY : tcp_pkg::RESP_SLVERR;
      end else if (rvalid_r & axi_req.rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  always_comb begin
    axi_rsp.awready = awready_r;
    axi_rsp.wready  = wready_r;
    axi_rsp.bvalid  = bvalid_r;
    axi_rsp.bresp   = bresp_r;
    axi_rsp.arready = arready_r;
    axi_rsp.rvalid  = rvalid_r;
    axi_rsp.rdata   = rdata_r;
    axi_rsp.rresp   = rresp_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter core

  localparam int          MEAS_TYPE_BIT = tcp_pkg::MEAS_TYPE_POS;
  localparam logic [15:0] COUNT_ZERO    = tcp_pkg::COUNT_RST;

  wire       running     = start_r;
  wire [7:0] new_mode    = w_data_r[7:0];
  wire       type_change = wr_mode & start_r & (w_data_r[MEAS_TYPE_BIT] != mode_r.meas_type);

  wire ev_step   = ~meas_mode & running & eff_edge;
  wire underflow = ev_step & (counter_r == '0);
  wire ms_edge_q = meas_mode & running & eff_edge;
  wire ms_tick   = meas_mode & running & src_tick & ~ms_edge_q;
  wire overflow  = ms_tick & (counter_r == '1);
  wire ms_report = ms_edge_q & primed_r;

  wire irq_set = underflow | ms_report | overflow | type_change;
  wire irq_clr = wr_status & w_data_r[tcp_pkg::ST_IRQ_POS];

  // Next counter value
  logic [CNT_W-1:0] counter_nxt;
  logic [CNT_W-1:0] reload_nxt;
  always_comb begin
    counter_nxt = counter_r;
    reload_nxt  = reload_r;
    if (!meas_mode) begin
      if (wr_count) begin
        reload_nxt = wr_value;
        if (!running) begin
          counter_nxt = wr_value;
        end
      end
      if (underflow) begin
        counter_nxt = reload_r;
      end else if (ev_step) begin
        counter_nxt = counter_r - 1'b1;
      end
    end else if (ms_edge_q) begin
      reload_nxt  = counter_r;
      counter_nxt = COUNT_ZERO;
    end else if (ms_tick) begin
      counter_nxt = counter_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_r     <= tcp_pkg::tcp_mode_t'(tcp_pkg::MODE_RST);
      start_r    <= 1'b0;
      counter_r  <= tcp_pkg::COUNT_RST;
      reload_r   <= tcp_pkg::COUNT_RST;
      irq_r      <= 1'b0;
      ovf_r      <= 1'b0;
      primed_r   <= 1'b0;
      main_div_r <= 5'h00;
      sub_div_r  <= 5'h00;
      irq_request <= 1'b0;
    end else begin
      counter_r  <= counter_nxt;
      reload_r   <= reload_nxt;
      main_div_r <= main_div_r + 5'h01;
      if (sub_tick) begin
        sub_div_r <= sub_div_r + 5'h01;
      end
      if (wr_mode) begin
        mode_r <= tcp_pkg::tcp_mode_t'(new_mode);
      end
      if (wr_start) begin
        start_r <= w_data_r[0];
      end
      if (wr_start & w_data_r[0] & ~start_r) begin
        primed_r <= 1'b0;
        counter_r <= meas_mode ? COUNT_ZERO : counter_nxt;
      end else if (ms_edge_q) begin
        primed_r <= 1'b1;
      end
      if (overflow) begin
        ovf_r <= 1'b1;
      end else if (wr_mode & start_r) begin
        ovf_r <= 1'b0;
      end
      if (irq_set) begin
        irq_r <= 1'b1;
      end else if (irq_clr) begin
        irq_r <= 1'b0;
      end
      irq_request <= irq_set | (irq_r & ~irq_clr);
    end
  end

endmodule

`default_nettype wire

// *** logic/tcp_pkg.sv ***
// Package: register map, field layout and types of the capture timer channel
package tcp_pkg;

  // Register byte offsets
  localparam logic [3:0] OFF_COUNT  = 4'h0;
  localparam logic [3:0] OFF_MODE   = 4'h4;
  localparam logic [3:0] OFF_START  = 4'h8;
  localparam logic [3:0] OFF_STATUS = 4'hc;

  // Mode register fields
  localparam int MODE_SEL_POS  = 0;  // 0 event counter, 1 measurement
  localparam int EDGE_SEL_POS  = 1;  // 2 bits, event counter edge select
  localparam int MEAS_TYPE_POS = 3;  // 0 period, 1 width
  localparam int CLK_SEL_POS   = 6;  // 2 bits: clock_select_low / clock_select_high

  // Status register fields
  localparam int ST_IRQ_POS  = 0;
  localparam int ST_OVF_POS  = 1;
  localparam int ST_PRIM_POS = 2;

  // Reset values
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [7:0]  MODE_RST  = 8'h00;

  // Clock divider counts
  localparam int DIV_MAIN8   = 8;
  localparam int DIV_MAIN32  = 32;
  localparam int DIV_SUB32   = 32;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    EDGE_RISE = 2'b00,
    EDGE_FALL = 2'b01,
    EDGE_BOTH = 2'b10
  } tcp_edge_t;

  typedef enum logic [1:0] {
    SRC_MAIN_DIV1  = 2'b00,
    SRC_MAIN_DIV8  = 2'b01,
    SRC_MAIN_DIV32 = 2'b10,
    SRC_SUB_DIV32  = 2'b11
  } tcp_src_t;

  typedef struct packed {
    logic [1:0] clk_sel;
    logic [1:0] rsvd;
    logic       meas_type;
    logic [1:0] edge_sel;
    logic       mode_sel;
  } tcp_mode_t;

  typedef struct packed {
    logic [3:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [3:0]  araddr;
    logic        arvalid;
    logic        rready;
  } tcp_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } tcp_axi_rsp_t;

endpackage

// *** dv/tcp_pin_model.sv ***
// Far-side model: measured pulse source and free-running sub-clock
`timescale 1ns/1ps
`default_nettype none
module tcp_pin_model (
  input  wire logic clk,
  output logic      pin,
  output logic      sub_tick
);
  initial begin
    pin = 1'b0;
    sub_tick = 1'b0;
    // Half period chosen off the main clock grid
    forever #35.3 sub_tick = ~sub_tick;
  end
  //////////////////////////////////////////
  // Pulses start on a clock edge; pin rests low between calls
  task automatic pulses(input int n, input int hi, input int lo);
    repeat (n) begin
      pin <= 1'b1;
      repeat (hi) @(posedge clk);
      pin <= 1'b0;
      repeat (lo) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// *** dv/tcp_capture_timer_properties.sv ***
// Port checker for the capture timer channel
`timescale 1ns/1ps
`default_nettype none
module tcp_props #(
  parameter int CNT_W = 16
) (
  input wire logic                  clk,
  input wire logic                  rst,
  input wire tcp_pkg::tcp_axi_req_t axi_req,
  input wire tcp_pkg::tcp_axi_rsp_t axi_rsp,
  input wire logic                  capture_input_pin,
  input wire logic                  subclock_tick,
  input wire logic                  irq_request
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  //////////////////////////////////////////
  property p_bhold;
    axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold;
    axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_rlat;
    axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_blat;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready |-> ##[1:2] axi_rsp.bvalid;
  endproperty
  a_blat: assert property (p_blat) else $error("write answer late");
  property p_arref;
    axi_rsp.rvalid |-> !axi_rsp.arready;
  endproperty
  a_arref: assert property (p_arref) else $error("read taken during answer");
  property p_awref;
    axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready;
  endproperty
  a_awref: assert property (p_awref) else $error("write taken during answer");
  property p_slverr;
    axi_rsp.rvalid && axi_rsp.rresp == tcp_pkg::RESP_SLVERR |-> axi_rsp.rdata == 32'h0;
  endproperty
  a_slverr: assert property (p_slverr) else $error("error read carries data");
  // Request only drops after a status write
  property p_irqfall;
    $fell(irq_request) |-> axi_rsp.bvalid || $past(axi_rsp.bvalid) || $past(axi_rsp.bvalid, 2);
  endproperty
  a_irqfall: assert property (p_irqfall) else $error("request dropped alone");
  c_irq: cover property ($rose(irq_request));
  c_err: cover property (axi_rsp.rvalid && axi_rsp.rresp == tcp_pkg::RESP_SLVERR);
  c_bst: cover property (axi_rsp.bvalid && !axi_req.bready);
endmodule
bind tcp_capture_timer tcp_props #(.CNT_W(CNT_W)) u_props (.clk(clk), .rst(rst), .axi_req(axi_req),
  .axi_rsp(axi_rsp), .capture_input_pin(capture_input_pin), .subclock_tick(subclock_tick), .irq_request(irq_request));
`default_nettype wire

// *** dv/test_timer_event_count_pulse_measure.sv ***
// Bench for the capture timer channel
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s exp %0h got %0h", n, e, g); end end
module test_timer_event_count_pulse_measure;
  logic                  clk;
  logic                  rst;
  logic                  pin;
  logic                  tick;
  logic                  irq;
  tcp_pkg::tcp_axi_req_t rq;
  tcp_pkg::tcp_axi_rsp_t rs;
  int                    fail_count, checked, cnt, rld, k, n, e, x;
  logic [31:0]           d;
  logic [1:0]            rr;
  bit                    iq;
  tcp_capture_timer dut (.clk(clk), .rst(rst), .axi_req(rq), .axi_rsp(rs), .capture_input_pin(pin),
    .subclock_tick(tick), .irq_request(irq));
  tcp_pin_model pm (.clk(clk), .pin(pin), .sub_tick(tick));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  //////////////////////////////////////////
  // Response ready is raised late so the hold of the answer is exercised
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    rq.awaddr <= a;
    rq.wdata <= v;
    rq.awvalid <= 1'b1;
    rq.wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (rs.awready) rq.awvalid <= 1'b0;
      if (rs.wready) rq.wvalid <= 1'b0;
    end while (!rs.bvalid);
    rq.bready <= 1'b1;
    @(posedge clk);
    rq.bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    rq.araddr <= a;
    rq.arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (rs.arready) rq.arvalid <= 1'b0;
    end while (!rs.rvalid);
    rq.rready <= 1'b1;
    @(posedge clk);
    d = rs.rdata;
    rr = rs.rresp;
    rq.rready <= 1'b0;
  endtask
  // Reference counter of the event mode
  task automatic step(input int m);
    repeat (m) begin
      if (cnt == 0) begin
        cnt = rld;
        iq = 1'b1;
      end else cnt--;
    end
  endtask
  task automatic report_and_stop;
    $display("checked %0d errors %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (95000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end
  //////////////////////////////////////////
  initial begin
    rq = '0;
    rq.wstrb = 4'hf;
    rst = 1'b1;
    fail_count = 0;
    checked = 0;
    x = $urandom(32'h0c18);
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(tcp_pkg::OFF_STATUS);
    `CHK("status", 0, d)
    rd(4'h2);
    `CHK("bad resp", tcp_pkg::RESP_SLVERR, rr)
    `CHK("bad data", 0, d)
    for (int m = 0; m < 3; m++) begin
      n = $urandom_range(3, 0);
      k = $urandom_range(5, 1);
      e = (m == 2) ? 2 : 1;
      wr(tcp_pkg::OFF_START, 0);
      wr(tcp_pkg::OFF_MODE, m << tcp_pkg::EDGE_SEL_POS);
      wr(tcp_pkg::OFF_STATUS, 1);
      wr(tcp_pkg::OFF_COUNT, n);
      cnt = n;
      rld = n;
      iq = 1'b0;
      wr(tcp_pkg::OFF_START, 1);
      pm.pulses(k, 3, 6);
      step(k * e);
      rd(tcp_pkg::OFF_COUNT);
      `CHK("count", cnt, d[15:0])
      `CHK("irq", iq, irq)
      wr(tcp_pkg::OFF_COUNT, 9);
      rld = 9;
      pm.pulses(1, 3, 6);
      step(e);
      rd(tcp_pkg::OFF_COUNT);
      `CHK("reload", cnt, d[15:0])
      wr(tcp_pkg::OFF_START, 0);
      pm.pulses(1, 3, 6);
      rd(tcp_pkg::OFF_COUNT);
      `CHK("stopped", cnt, d[15:0])
    end
    for (int s = 0; s < 4; s++) begin
      e = (s == 0) ? 1120 : (s == 1) ? 140 : (s == 2) ? 35 : 5;
      wr(tcp_pkg::OFF_START, 0);
      wr(tcp_pkg::OFF_MODE, 1 | s << tcp_pkg::CLK_SEL_POS);
      wr(tcp_pkg::OFF_STATUS, 1);
      wr(tcp_pkg::OFF_START, 1);
      pm.pulses(1, 560, 560);
      `CHK("first", 0, irq)
      pm.pulses(2, 560, 560);
      rd(tcp_pkg::OFF_COUNT);
      `CHK("period", 1, (d + 1 >= e && d <= e + 1))
      `CHK("irq meas", 1, irq)
    end
    wr(tcp_pkg::OFF_START, 0);
    wr(tcp_pkg::OFF_MODE, 1 | 1 << tcp_pkg::MEAS_TYPE_POS);
    wr(tcp_pkg::OFF_STATUS, 1);
    wr(tcp_pkg::OFF_START, 1);
    pm.pulses(1, 100, 300);
    `CHK("width irq", 1, irq)
    rd(tcp_pkg::OFF_COUNT);
    `CHK("width", 1, (d + 1 >= 100 && d <= 101))
    x = d;
    wr(tcp_pkg::OFF_COUNT, 5);
    rd(tcp_pkg::OFF_COUNT);
    `CHK("no write", x, d)
    wr(tcp_pkg::OFF_STATUS, 1);
    wr(tcp_pkg::OFF_MODE, 1);
    repeat (2) @(posedge clk);
    `CHK("type chg", 1, irq)
    wr(tcp_pkg::OFF_STATUS, 1);
    repeat (65600) @(posedge clk);
    rd(tcp_pkg::OFF_STATUS);
    `CHK("overflow", 2'b11, d[1:0])
    wr(tcp_pkg::OFF_MODE, 1);
    rd(tcp_pkg::OFF_STATUS);
    `CHK("ovf clear", 0, d[1])
    report_and_stop();
  end
endmodule
`default_nettype wire
